// *** core/adem_cfg.svh ***
// offsets, field positions, reset values and timing counts of the diagnostic monitor
`ifndef ADEM_CFG_SVH
`define ADEM_CFG_SVH
`define ADEM_NCH 8
`define ADEM_OFF_CTRL 8'h00
`define ADEM_OFF_MUX 8'h04
`define ADEM_OFF_ROUTE 8'h08
`define ADEM_OFF_CHERR 8'h0c
`define ADEM_OFF_GENERR 8'h10
`define ADEM_OFF_STATUS 8'h14
`define ADEM_OFF_SARRES 8'h18
`define ADEM_CTRL_RST 10'h307
`define ADEM_B_MODEN 0
`define ADEM_B_FILTEN 1
`define ADEM_B_CLIPEN 2
`define ADEM_B_CRCEN 3
`define ADEM_B_CLKTST 4
`define ADEM_B_IRDTST 5
`define ADEM_B_IWRTST 6
`define ADEM_B_AUXRD 7
`define ADEM_B_DEGL 8
`define ADEM_GE_CRC 0
`define ADEM_GE_CLK 1
`define ADEM_GE_IRD 2
`define ADEM_GE_IWR 3
`define ADEM_MOD_RUN 5'd20
`define ADEM_FS_PCT 20
`define ADEM_SAR_MAX 5'd21
`define ADEM_DIAG_MAX 4'd9
`define ADEM_CRC_POLY 8'h07
`define ADEM_DEGL_TENTHS 15
`define ADEM_DEGL_CYC ((`ADEM_DEGL_TENTHS + 9) / 10)
`endif

// *** core/adem_pkg.sv ***
// shared types of the diagnostic monitor
package adem_pkg;
`include "adem_cfg.svh"
  typedef enum logic [3:0] {
    ADEM_PH_CMD = 4'b0001,
    ADEM_PH_DATA = 4'b0010,
    ADEM_PH_CRC = 4'b0100,
    ADEM_PH_DONE = 4'b1000
  } adem_phase_t;

  typedef struct packed {
    logic [9:0] ctrl;
    logic [4:0] sar_mux;
    logic [3:0] diag_mux;
    logic [`ADEM_NCH-1:0] route;
    logic [`ADEM_NCH-1:0] refmon;
    logic [1:0] ref_mux;
    logic [3:0] gen_err;
    logic spi_alert;
    logic rd_seen;
    logic [11:0] sar_res;
    adem_phase_t ph;
    logic [7:0] cmd;
    logic [7:0] wdat;
    logic wpend;
    logic [7:0] crc;
    logic [7:0] tx;
    logic tx_lo;
    logic [31:0] rdata;
    logic [1:0] trig_sy;
    logic [1:0] trig_cnt;
    logic trig_out;
  } adem_top_st_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] d;
    logic [2:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
  } adem_shift_st_t;
endpackage

// *** core/adem_spi_if.sv ***
// byte-level link between the serial shifter and the monitor core
`timescale 1ns/1ps
interface adem_spi_if;
  logic frame_start;
  logic frame_end;
  logic misaligned;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  modport shifter (output frame_start, frame_end, misaligned, byte_valid, rx_byte, input tx_byte);
  modport core (input frame_start, frame_end, misaligned, byte_valid, rx_byte, output tx_byte);
endinterface

// *** core/adem_spi_shift.sv ***
// serial target shifter: pin sync, edge find, bit count, byte in and out
`timescale 1ns/1ps
module adem_spi_shift
  import adem_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  adem_spi_if.shifter bus
);
  adem_shift_st_t st_r;
  adem_shift_st_t st_nxt;
  logic active;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // edges only from second sync stage against its delayed copy
  assign active = ~st_r.s2[2];
  assign rise = active & st_r.s2[1] & ~st_r.d[1];
  assign fall = active & ~st_r.s2[1] & st_r.d[1];
  assign bus.frame_start = st_r.d[2] & ~st_r.s2[2];
  assign bus.frame_end = ~st_r.d[2] & st_r.s2[2];
  assign bus.misaligned = st_r.bitcnt != 3'd0; // RULE_10
  assign bus.byte_valid = rise && st_r.bitcnt == 3'd7;
  assign bus.rx_byte = {st_r.rx[6:0], st_r.s2[0]};
  assign sdo = st_r.tx[7];
  assign sdo_oe = active;

  // sclk is sampled, so it must stay well below clk/4
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {cs_n, sclk, sdi};
    st_nxt.s2 = st_r.s1;
    st_nxt.d = st_r.s2;
    if (bus.frame_start)
    begin
      st_nxt.bitcnt = 3'd0;
      st_nxt.tx = bus.tx_byte;
    end
    if (rise)
    begin
      st_nxt.bitcnt = st_r.bitcnt + 3'd1;
      st_nxt.rx = {st_r.rx[6:0], st_r.s2[0]};
    end
    if (fall)
    begin
      // next byte is loaded after the eighth edge, giving the core time to answer
      if (st_r.bitcnt == 3'd0)
        st_nxt.tx = bus.tx_byte;
      else
        st_nxt.tx = {st_r.tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st_r <= '{s1: 3'b100, s2: 3'b100, d: 3'b100, default: '0};
    else
      st_r <= st_nxt;
  end
endmodule

// *** core/adem_chan.sv ***
// one converter channel: modulator, filter and output saturation watch
`timescale 1ns/1ps
module adem_chan
  import adem_pkg::*;
#(
  parameter int W = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mod_bit,
  input wire logic mod_valid,
  input wire logic smp_valid,
  input wire logic signed [W+1:0] filt_val,
  input wire logic signed [W+1:0] cal_val,
  input wire logic [2:0] chk_en,
  input wire logic flag_clr,
  output logic [2:0] flags,
  output logic [W-1:0] out_data
);
  localparam logic signed [W+1:0] FS_POS = (W+2)'((64'sd1 <<< (W-1)) - 64'sd1);
  localparam logic signed [W+1:0] FS_NEG = (W+2)'(-(64'sd1 <<< (W-1)));
  localparam logic signed [W+1:0] FILT_LIM =
    (W+2)'(((64'sd1 <<< (W-1)) * (64'sd100 + `ADEM_FS_PCT)) / 64'sd100);

  typedef struct packed {
    logic [4:0] run;
    logic last;
    logic filt_c;
    logic clip_c;
    logic [2:0] flags;
    logic [W-1:0] out;
  } adem_chan_st_t;

  adem_chan_st_t st_r;
  adem_chan_st_t st_nxt;
  logic [2:0] cond;

  assign cond = {st_r.clip_c, st_r.filt_c, st_r.run == `ADEM_MOD_RUN}; // RULE_01
  assign flags = st_r.flags;
  assign out_data = st_r.out;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    // run of identical modulator bits, restarted on any change
    if (mod_valid)
    begin
      if (mod_bit == st_r.last && st_r.run != 5'd0)
        st_nxt.run = (st_r.run == `ADEM_MOD_RUN) ? st_r.run : st_r.run + 5'd1; // RULE_25
      else
        st_nxt.run = 5'd1; // RULE_25
      st_nxt.last = mod_bit;
    end
    if (smp_valid)
    begin
      st_nxt.filt_c = filt_val > FILT_LIM || filt_val < -FILT_LIM; // RULE_04
      st_nxt.clip_c = cal_val > FS_POS || cal_val < FS_NEG;
      // clamp, never wrap
      if (cal_val > FS_POS)
        st_nxt.out = FS_POS[W-1:0]; // RULE_06
      else if (cal_val < FS_NEG)
        st_nxt.out = FS_NEG[W-1:0]; // RULE_06
      else
        st_nxt.out = cal_val[W-1:0];
    end
    // sticky, set wins; a read clears only a condition already gone
    for (int i = 0; i < 3; i++)
      st_nxt.flags[i] = (cond[i] & chk_en[i]) | (st_r.flags[i] & ~(flag_clr & ~cond[i])); // RULE_02 RULE_03 RULE_05 RULE_24
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_mod_run;
    st_r.run == `ADEM_MOD_RUN && chk_en[0];
  endsequence
  a_mod_sat_set: assert property (s_mod_run |=> flags[0]) // RULE_01
    else $error("modulator run not flagged");
  a_mod_sat_off: assert property ($rose(flags[0]) |-> $past(chk_en[0])) // RULE_03
    else $error("modulator flag raised while disabled");
  a_flag_keep: assert property (flag_clr && cond[1] && flags[1] |=> flags[1]) // RULE_02
    else $error("active filter flag cleared by read");
  a_clip_clamp: assert property (smp_valid && cal_val > FS_POS |=> out_data == FS_POS[W-1:0]) // RULE_06
    else $error("output not clamped at full scale");
  a_filt_off: assert property ($rose(flags[1]) |-> $past(chk_en[1])) // RULE_05
    else $error("filter flag raised while disabled");
endmodule

// *** core/adem_top.sv ***
// diagnostic and error monitor of a multichannel sigma-delta converter
// Functional notes
// (RULE_01) each channel flags 20 consecutive identical modulator outputs
// (RULE_02) reading a saturation flag clears it only if the condition is gone
// (RULE_03) modulator check disabled means no modulator flag
// (RULE_04) filter output about 20 percent past full scale sets filter flag
// (RULE_05) filter and output checks each gated by own enable
// (RULE_06) calibrated output clamps at full scale and sets clip flag
// (RULE_07) serial errors stay until the general error register is read
// (RULE_08) serial alert holds until that read and a new frame
// (RULE_09) checksum mismatch sets error and blocks the write
// (RULE_10) clock count not multiple of 8 sets error, last whole command runs
// (RULE_11) clock count test bit turns that check off
// (RULE_12) read of missing register sets error unless disabled
// (RULE_13) write of missing register sets error unless disabled
// (RULE_14) auxiliary converter results are 12 bits
// (RULE_15) host pulses the trigger pin no faster than 256 kHz
// (RULE_16) host reads previous result before next trigger
// (RULE_17) readout enable makes every output bit come from the result; the code sends 4 zero bits ahead of the 12-bit result
// (RULE_18) deglitch 11 passes trigger, 10 needs 1.5 clock cycles high
// (RULE_19) auxiliary input pair select codes 0 to 21
// (RULE_20) shared diagnostic input select codes 0 to 9
// (RULE_21) route bit sends channel to diagnostic input, reference per mux bits
// (RULE_22) reference monitor bit routes and forces supply reference
// (RULE_23) alert high while an enabled diagnostic sees an error
// (RULE_24) flags sticky, gated by enable, alert is OR of flags
// (RULE_25) modulator run count restarts whenever the bit changes
`timescale 1ns/1ps
module adem_top
  import adem_pkg::*;
#(
  parameter int W = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic [`ADEM_NCH-1:0] mod_bits,
  input wire logic mod_valid,
  input wire logic smp_valid,
  input wire logic [`ADEM_NCH*(W+2)-1:0] filt_vals,
  input wire logic [`ADEM_NCH*(W+2)-1:0] cal_vals,
  output logic [`ADEM_NCH*W-1:0] ch_out,
  input wire logic aux_conversion_trigger,
  output logic sar_trigger,
  input wire logic sar_done,
  input wire logic [11:0] sar_data,
  output logic [4:0] sar_input_select,
  output logic [3:0] diag_input_select,
  output logic [`ADEM_NCH-1:0] diag_input_route,
  output logic [`ADEM_NCH-1:0] supply_reference_monitor,
  output logic [1:0] ref_mux_select,
  output logic alert
);
  localparam logic [1:0] DEGL_CYC = 2'(`ADEM_DEGL_CYC);
  localparam adem_top_st_t ST_RST = '{ctrl: `ADEM_CTRL_RST, ph: ADEM_PH_CMD, default: '0};

  adem_top_st_t st_r;
  adem_top_st_t n;
  adem_spi_if spi ();
  logic [3*`ADEM_NCH-1:0] fl;
  logic ch_clr;
  logic [3:0] ge_set;

  ////////////////////////////////////////////////////////////////////////////
  // register helpers: rd_val and wr_reg shared by the plain and serial ports, idx_ok and crc8 used by the serial port only
  function automatic logic idx_ok(input logic [6:0] i);
    return i <= 7'({`ADEM_OFF_SARRES} >> 2);
  endfunction

  function automatic logic [31:0] rd_val(input adem_top_st_t s, input logic [5:0] i,
                                         input logic [3*`ADEM_NCH-1:0] f);
    logic [7:0] a;
    a = {i, 2'b00};
    rd_val = 32'h0;
    if (a == `ADEM_OFF_CTRL)
      rd_val = {22'h0, s.ctrl};
    else if (a == `ADEM_OFF_MUX)
      rd_val = {20'h0, s.diag_mux, 3'h0, s.sar_mux};
    else if (a == `ADEM_OFF_ROUTE)
      rd_val = {14'h0, s.ref_mux, s.refmon, s.route};
    else if (a == `ADEM_OFF_CHERR)
      rd_val = {8'h0, f};
    else if (a == `ADEM_OFF_GENERR)
      rd_val = {28'h0, s.gen_err};
    else if (a == `ADEM_OFF_STATUS)
      rd_val = {29'h0, s.spi_alert, |f, s.spi_alert | (|f)};
    else if (a == `ADEM_OFF_SARRES)
      rd_val = {20'h0, s.sar_res}; // RULE_14
  endfunction

  function automatic adem_top_st_t wr_reg(input adem_top_st_t s, input logic [5:0] i,
                                          input logic [31:0] v);
    logic [7:0] a;
    a = {i, 2'b00};
    wr_reg = s;
    if (a == `ADEM_OFF_CTRL)
      wr_reg.ctrl = v[9:0];
    else if (a == `ADEM_OFF_MUX)
    begin
      // out-of-range codes are dropped so the selector never sees them
      if (v[4:0] <= `ADEM_SAR_MAX)
        wr_reg.sar_mux = v[4:0]; // RULE_19
      if (v[11:8] <= `ADEM_DIAG_MAX)
        wr_reg.diag_mux = v[11:8]; // RULE_20
    end
    else if (a == `ADEM_OFF_ROUTE)
    begin
      wr_reg.route = v[7:0];
      wr_reg.refmon = v[15:8];
      wr_reg.ref_mux = v[17:16];
    end
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int k = 0; k < 8; k++)
      r = r[7] ? ({r[6:0], 1'b0} ^ `ADEM_CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter and channel watchers
  adem_spi_shift u_shift (
    .clk(clk),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .bus(spi.shifter)
  );

  for (genvar c = 0; c < `ADEM_NCH; c++)
  begin : g_ch
    logic [2:0] f3;
    adem_chan #(.W(W)) u_chan (
      .clk(clk),
      .resetn(resetn),
      .mod_bit(mod_bits[c]),
      .mod_valid(mod_valid),
      .smp_valid(smp_valid),
      .filt_val(filt_vals[c*(W+2) +: W+2]),
      .cal_val(cal_vals[c*(W+2) +: W+2]),
      .chk_en({st_r.ctrl[`ADEM_B_CLIPEN], st_r.ctrl[`ADEM_B_FILTEN], st_r.ctrl[`ADEM_B_MODEN]}),
      .flag_clr(ch_clr),
      .flags(f3),
      .out_data(ch_out[c*W +: W])
    );
    // field layout: modulator, filter, clip bytes
    assign fl[c] = f3[0];
    assign fl[`ADEM_NCH + c] = f3[1];
    assign fl[2*`ADEM_NCH + c] = f3[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign reg_rdata = st_r.rdata;
  assign spi.tx_byte = st_r.tx;
  assign sar_trigger = st_r.trig_out;
  assign sar_input_select = st_r.sar_mux; // RULE_19
  assign diag_input_select = st_r.diag_mux; // RULE_20
  assign diag_input_route = st_r.route | st_r.refmon; // RULE_21 RULE_22
  assign supply_reference_monitor = st_r.refmon; // RULE_22
  assign ref_mux_select = st_r.ref_mux; // RULE_21
  assign alert = st_r.spi_alert | (|fl); // RULE_23 RULE_24

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = st_r;
    ge_set = 4'h0;
    ch_clr = 1'b0;
    n.rdata = 32'h0;
    // plain register port, read data stands one cycle only
    if (reg_wr)
      n = wr_reg(n, reg_addr[7:2], reg_wdata);
    if (reg_rd)
    begin
      n.rdata = rd_val(st_r, reg_addr[7:2], fl);
      if (reg_addr == `ADEM_OFF_CHERR)
        ch_clr = 1'b1; // RULE_02
      if (reg_addr == `ADEM_OFF_GENERR)
      begin
        n.gen_err = 4'h0; // RULE_07
        n.rd_seen = 1'b1; // RULE_08
      end
    end
    // serial frame: command byte, data byte, optional checksum byte
    if (spi.frame_start)
    begin
      n.ph = ADEM_PH_CMD;
      n.crc = 8'h00;
      n.wpend = 1'b0;
      if (st_r.rd_seen)
      begin
        n.spi_alert = 1'b0; // RULE_08
        n.rd_seen = 1'b0;
      end
    end
    if (spi.byte_valid)
    begin
      n.tx_lo = ~st_r.tx_lo;
      unique case (st_r.ph)
        ADEM_PH_CMD:
        begin
          n.cmd = spi.rx_byte;
          n.crc = crc8(st_r.crc, spi.rx_byte);
          n.ph = ADEM_PH_DATA;
          n.tx = 8'h00;
          if (spi.rx_byte[7] && idx_ok(spi.rx_byte[6:0]))
          begin
            n.tx = 8'(rd_val(st_r, spi.rx_byte[5:0], fl));
            if ({spi.rx_byte[5:0], 2'b00} == `ADEM_OFF_CHERR)
              ch_clr = 1'b1; // RULE_02
            if ({spi.rx_byte[5:0], 2'b00} == `ADEM_OFF_GENERR)
            begin
              n.gen_err = 4'h0; // RULE_07
              n.rd_seen = 1'b1;
            end
          end
          else if (spi.rx_byte[7] && !st_r.ctrl[`ADEM_B_IRDTST])
            ge_set[`ADEM_GE_IRD] = 1'b1; // RULE_12
        end
        ADEM_PH_DATA:
        begin
          n.wdat = spi.rx_byte;
          n.crc = crc8(st_r.crc, spi.rx_byte);
          n.ph = ADEM_PH_DONE;
          if (!st_r.cmd[7] && st_r.ctrl[`ADEM_B_CRCEN])
            n.ph = ADEM_PH_CRC;
          else if (!st_r.cmd[7])
            n.wpend = 1'b1;
        end
        ADEM_PH_CRC:
        begin
          n.ph = ADEM_PH_DONE;
          // mismatch leaves the target register untouched
          if (spi.rx_byte == st_r.crc)
            n.wpend = 1'b1;
          else
            ge_set[`ADEM_GE_CRC] = 1'b1; // RULE_09
        end
        ADEM_PH_DONE:
        begin
          n.ph = ADEM_PH_DONE;
        end
      endcase
    end
    // write runs at frame end, so trailing partial bits never reach it
    if (spi.frame_end)
    begin
      if (spi.misaligned && !st_r.ctrl[`ADEM_B_CLKTST])
        ge_set[`ADEM_GE_CLK] = 1'b1; // RULE_10 RULE_11
      if (st_r.wpend && idx_ok(st_r.cmd[6:0]))
        n = wr_reg(n, st_r.cmd[5:0], {24'h0, st_r.wdat}); // RULE_10
      else if (st_r.wpend && !st_r.ctrl[`ADEM_B_IWRTST])
        ge_set[`ADEM_GE_IWR] = 1'b1; // RULE_13
      n.wpend = 1'b0;
      n.tx_lo = 1'b0;
      n.tx = 8'h00;
      n.ph = ADEM_PH_CMD;
    end
    // new errors win over a clear in the same cycle
    n.gen_err = n.gen_err | ge_set; // RULE_07 RULE_24
    if (|ge_set)
    begin
      n.spi_alert = 1'b1; // RULE_08 RULE_23
      n.rd_seen = 1'b0;
    end
    // auxiliary result readout owns the serial output
    if (sar_done)
      n.sar_res = sar_data; // RULE_14 RULE_16
    if (n.ctrl[`ADEM_B_AUXRD])
      n.tx = n.tx_lo ? n.sar_res[7:0] : {4'h0, n.sar_res[11:8]}; // RULE_17
    // trigger pin synchroniser and deglitch
    n.trig_sy = {st_r.trig_sy[0], aux_conversion_trigger}; // RULE_15
    if (!st_r.trig_sy[1])
      n.trig_cnt = 2'd0;
    else if (st_r.trig_cnt != DEGL_CYC)
      n.trig_cnt = st_r.trig_cnt + 2'd1;
    if (st_r.ctrl[`ADEM_B_DEGL +: 2] == 2'b11)
      n.trig_out = st_r.trig_sy[1]; // RULE_18
    else
      n.trig_out = st_r.trig_sy[1] && n.trig_cnt >= DEGL_CYC; // RULE_18
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st_r <= ST_RST;
    else
      st_r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_trig_held;
    st_r.trig_sy[1] [*2];
  endsequence
  sequence s_crc_bad;
    spi.byte_valid && st_r.ph == ADEM_PH_CRC && spi.rx_byte != st_r.crc;
  endsequence
  a_crc_bad: assert property (s_crc_bad |=> st_r.gen_err[0] && !st_r.wpend) // RULE_09
    else $error("checksum mismatch not caught");
  a_clk_count: assert property (spi.frame_end && spi.misaligned
    && !st_r.ctrl[`ADEM_B_CLKTST] |=> st_r.gen_err[1]) // RULE_10
    else $error("clock count error missed");
  a_clk_off: assert property ($rose(st_r.gen_err[1]) |-> !$past(st_r.ctrl[`ADEM_B_CLKTST])) // RULE_11
    else $error("clock count error while check off");
  a_inv_read: assert property (spi.byte_valid && st_r.ph == ADEM_PH_CMD && spi.rx_byte[7]
    && !idx_ok(spi.rx_byte[6:0]) && !st_r.ctrl[`ADEM_B_IRDTST] |=> st_r.gen_err[2]) // RULE_12
    else $error("invalid read not flagged");
  a_inv_write: assert property (spi.frame_end && st_r.wpend && !idx_ok(st_r.cmd[6:0])
    && !st_r.ctrl[`ADEM_B_IWRTST] |=> st_r.gen_err[3]) // RULE_13
    else $error("invalid write not flagged");
  a_alert_hold: assert property ($fell(st_r.spi_alert) |-> $past(spi.frame_start)) // RULE_08
    else $error("serial alert dropped without new frame");
  a_degl_pass: assert property (s_trig_held ##0 st_r.ctrl[9:8] == 2'b10 |=> sar_trigger) // RULE_18
    else $error("held trigger not passed");
  a_degl_block: assert property ($rose(sar_trigger) && st_r.ctrl[9:8] == 2'b10
    |-> $past(st_r.trig_sy[1], 1) && $past(st_r.trig_sy[1], 2)) // RULE_18
    else $error("short trigger passed");
  a_sar_range: assert property (st_r.sar_mux <= `ADEM_SAR_MAX) // RULE_19
    else $error("aux input code out of range");
  a_aux_readout: assert property (st_r.ctrl[`ADEM_B_AUXRD] |-> spi.tx_byte ==
    (st_r.tx_lo ? st_r.sar_res[7:0] : {4'h0, st_r.sar_res[11:8]})) // RULE_17
    else $error("serial output not from aux result");
endmodule

// *** tb/adem_host_model.sv ***
// host-side serial controller model driving the monitor's serial target pins
`timescale 1ns/1ps
module adem_host_model
(
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  // idle: not selected, clock parked low, data line driven high
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // mode 0 frame, msb first, 200 ns clock running only inside the frame
  // odd start offset keeps the link unrelated in phase to the system clock
  task automatic xfer(input int nb, input logic [23:0] d, output logic [23:0] q);
    q = 24'h0;
    #7 cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      sdi = d[23 - i];
      #100 sclk = 1'b1;
      q = {q[22:0], sdo & sdo_oe};
      #100 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    sdi = 1'b1;
    // give the write at frame end time to land
    #400;
  endtask
endmodule

// *** tb/adem_top_test.sv ***
// self-checking bench of the diagnostic and error monitor
`timescale 1ns/1ps
module adem_top_test;
  import adem_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mod_valid = 1'b0;
  logic smp_valid = 1'b0;
  logic trig = 1'b0;
  logic sar_done = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] mod_bits = 8'h00;
  logic [11:0] sar_data = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [23:0] q;
  logic [207:0] filt_vals = 208'h0;
  logic [207:0] cal_vals = 208'h0;
  logic [191:0] ch_out;
  logic [7:0] route, refmon;
  logic [4:0] sar_sel;
  logic [3:0] diag_sel;
  logic [1:0] ref_sel;
  logic sclk, cs_n, sdi, sdo, sdo_oe, sar_trigger, alert;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  adem_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .mod_bits(mod_bits), .mod_valid(mod_valid),
    .smp_valid(smp_valid), .filt_vals(filt_vals), .cal_vals(cal_vals), .ch_out(ch_out),
    .aux_conversion_trigger(trig), .sar_trigger(sar_trigger), .sar_done(sar_done),
    .sar_data(sar_data), .sar_input_select(sar_sel), .diag_input_select(diag_sel),
    .diag_input_route(route), .supply_reference_monitor(refmon), .ref_mux_select(ref_sel),
    .alert(alert));
  adem_host_model host (.sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // register port: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic mrun(input logic [7:0] b, input int n);
    repeat (n)
    begin
      @(posedge clk);
      mod_bits <= b;
      mod_valid <= 1'b1;
      @(posedge clk);
      mod_valid <= 1'b0;
    end
  endtask
  // checksum as the host computes it, independent of the device
  function automatic logic [7:0] crc8(input logic [15:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(8'h00, 32'h307);
    check(alert, 1'b0);
    for (int i = 0; i < 23; i++)
    begin
      wr(8'h04, {20'h0, 4'(i > 10 ? 9 : i), 3'h0, 5'(i)});
      @(posedge clk);
      #1 check(sar_sel, i > 21 ? 21 : i);
      check(diag_sel, i > 9 ? 9 : i);
    end
    wr(8'h08, 32'h00020410);
    @(posedge clk);
    #1 check(route, 8'h14);
    check(refmon, 8'h04);
    check(ref_sel, 2'h2);
    $display("done: registers and selectors");
  endtask
  task automatic t_mod;
    mrun(8'hff, 19);
    rchk(8'h0c, 32'h0);
    mrun(8'hff, 1);
    rchk(8'h0c, 32'hff);
    check(alert, 1'b1);
    rchk(8'h0c, 32'hff);
    mrun(8'h00, 10);
    rchk(8'h0c, 32'hff);
    rchk(8'h0c, 32'h0);
    mrun(8'hff, 10);
    rchk(8'h0c, 32'h0);
    wr(8'h00, 32'h306);
    mrun(8'h00, 25);
    rchk(8'h0c, 32'h0);
    mrun(8'hff, 1);
    $display("done: modulator run");
  endtask
  // ch0 filter just past the limit, ch0 and ch1 calibrated past both full scales
  task automatic t_sat(input logic [31:0] c, input logic [31:0] e);
    wr(8'h00, c);
    @(posedge clk);
    filt_vals[25:0] <= 26'h099999a;
    cal_vals[51:0] <= {26'h37ffffd, 26'h0800005};
    smp_valid <= 1'b1;
    @(posedge clk);
    smp_valid <= 1'b0;
    filt_vals <= 208'h0;
    cal_vals <= 208'h0;
    @(posedge clk);
    #1 check(ch_out[23:0], 24'h7fffff);
    check(ch_out[47:24], 24'h800000);
    rchk(8'h0c, e);
    check(alert, e != 0);
    @(posedge clk);
    smp_valid <= 1'b1;
    @(posedge clk);
    smp_valid <= 1'b0;
    rchk(8'h0c, e);
    rchk(8'h0c, 32'h0);
    $display("done: saturation checks");
  endtask
  task automatic t_ser;
    wr(8'h00, 32'h307);
    host.xfer(16, 24'h870000, q);
    rchk(8'h10, 32'h4);
    check(alert, 1'b1);
    rchk(8'h10, 32'h0);
    check(alert, 1'b1);
    host.xfer(16, 24'h800000, q);
    check(q[7:0], 8'h07);
    check(alert, 1'b0);
    host.xfer(17, 24'h010300, q);
    rchk(8'h10, 32'h2);
    check(sar_sel, 5'h03);
    host.xfer(16, 24'h070000, q);
    rchk(8'h10, 32'h8);
    wr(8'h00, 32'h377);
    host.xfer(17, 24'h870000, q);
    host.xfer(16, 24'h070000, q);
    rchk(8'h10, 32'h0);
    wr(8'h00, 32'h30f);
    host.xfer(24, {16'h0106, ~crc8(16'h0106)}, q);
    rchk(8'h10, 32'h1);
    check(sar_sel, 5'h03);
    host.xfer(24, {16'h0106, crc8(16'h0106)}, q);
    check(sar_sel, 5'h06);
    $display("done: serial errors");
  endtask
  // result is read out before any further trigger is given
  task automatic t_aux;
    @(posedge clk);
    sar_data <= 12'habc;
    sar_done <= 1'b1;
    @(posedge clk);
    sar_done <= 1'b0;
    rchk(8'h18, 32'habc);
    wr(8'h00, 32'h387);
    host.xfer(16, 24'h800000, q);
    check(q[15:0], 16'h0abc);
    $display("done: aux readout");
  endtask
  task automatic pulse(input int n, input logic e);
    logic s;
    s = 1'b0;
    @(posedge clk);
    trig <= 1'b1;
    repeat (n) @(posedge clk);
    trig <= 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      #1 s = s | sar_trigger;
    end
    check(s, e);
    // pin rate stays under the converter's limit
    repeat (160) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_mod;
    t_sat(32'h307, 32'h030100);
    t_sat(32'h301, 32'h0);
    t_ser;
    t_aux;
    wr(8'h00, 32'h307);
    pulse(1, 1'b1);
    wr(8'h00, 32'h207);
    pulse(1, 1'b0);
    pulse(2, 1'b1);
    $display("done: trigger deglitch");
    report_and_stop;
  end
  // hang guard well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      report_and_stop;
    end
  end
endmodule
